// ==== rtl/ppsc_consts.svh ====
`ifndef PPSC_CONSTS_SVH
`define PPSC_CONSTS_SVH

// Register map
`define PPSC_DYNPWR_ADDR 16'h4134
`define PPSC_FIXDEV_ADDR 16'h4135

// Reset and mode values
`define PPSC_DYNPWR_RST  8'hC1
`define PPSC_DYNPWR_DYN  8'h41
`define PPSC_FIXDEV_RST  8'h00
`define PPSC_RD_ZERO     8'h00
`define PPSC_PORTS_OFF   3'h0

// Field positions
`define PPSC_FIXDEV_MSB  2
`define PPSC_FIXDEV_LSB  0

// Fixed-device strap codes
`define PPSC_NR_NONE     2'h0
`define PPSC_NR_P1       2'h1
`define PPSC_NR_P12      2'h2
`define PPSC_FIX_NONE    3'h0
`define PPSC_FIX_P1      3'h1
`define PPSC_FIX_P12     3'h3
`define PPSC_FIX_ALL     3'h7

`endif

// ==== rtl/ppsc_pkg.sv ====
package ppsc_pkg;

  typedef logic [2:0] ppsc_ports_t;

  // Sequencer: hold, latch straps, run
  typedef enum logic [1:0] {
    PPSC_HOLD  = 2'h0,
    PPSC_LATCH = 2'h1,
    PPSC_RUN   = 2'h3
  } ppsc_state_t;

  // Status seen by hub logic
  typedef struct packed {
    ppsc_ports_t chargeSupport;
    ppsc_ports_t overcurrent;
    ppsc_ports_t fixedDevice;
    logic        selfPowered;
  } ppsc_status_t;

  // Raw pin levels after synchronisation
  typedef struct packed {
    logic        extRstN;
    logic        localSupply;
    ppsc_ports_t pinIn;
    ppsc_ports_t ocSense;
  } ppsc_pins_t;

endpackage

// ==== rtl/ppsc_sync.sv ====
`timescale 1ns/1ps
`default_nettype none

module ppsc_sync
  import ppsc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Levels
  input  wire ppsc_pins_t din,
  output ppsc_pins_t      dout
);

  ppsc_pins_t stage1_r;
  ppsc_pins_t stage1_nxt;
  ppsc_pins_t stage2_r;
  ppsc_pins_t stage2_nxt;

  // First stage feeds only the second
  always_comb
  begin
    stage1_nxt = ce ? din : stage1_r;
    stage2_nxt = ce ? stage1_r : stage2_r;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stage1_r <= '0;
      stage2_r <= '0;
    end
    else
    begin
      stage1_r <= stage1_nxt;
      stage2_r <= stage2_nxt;
    end
  end

  assign dout = stage2_r;

endmodule

`default_nettype wire

// ==== rtl/ppsc_port_power_strap_control.sv ====
// Behaviour
// - Each port drives own power enable
// - Combined pin: open-drain enable plus sense
// - Latch per-port battery charging strap
// - Sample local supply right after reset
// - Hold local supply value unless dynamic
// - Dynamic register resets 0xC1, 0x41 dynamic
// - Register written at run time, OTP load
// - Local detect used: fixed state from register
// - Straps captured at POR and reset rise
// - Local value 1 self, 0 bus powered
`timescale 1ns/1ps
`default_nettype none
`include "ppsc_consts.svh"

module ppsc_port_power_strap_control
  import ppsc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Chip pins
  input  wire logic        extResetN,
  input  wire logic        localSupplyDetect,
  input  wire logic [1:0]  fixedDeviceStraps,
  input  wire ppsc_ports_t portOvercurrentSense,
  // Shared power pin per port
  input  wire ppsc_ports_t portPinIn,
  output ppsc_ports_t      portPinOut,
  output ppsc_ports_t      portPinOe,
  // Configuration
  input  wire logic        combinedCtrlMode,
  input  wire logic        localDetectUsed,
  // Hub logic
  input  wire ppsc_ports_t portPowerReq,
  output ppsc_ports_t      portPowerEnable,
  output ppsc_status_t     status,
  output logic             configDone,
  // Register read/write port and OTP load
  input  wire logic        regWrEn,
  input  wire logic [15:0] regAddr,
  input  wire logic [7:0]  regWrData,
  output logic [7:0]       regRdData,
  input  wire logic        otpLoad,
  input  wire logic [7:0]  otpData
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  ppsc_pins_t pinsRaw;
  ppsc_pins_t pinsS;

  assign pinsRaw.extRstN     = extResetN;
  assign pinsRaw.localSupply = localSupplyDetect;
  assign pinsRaw.pinIn       = portPinIn;
  assign pinsRaw.ocSense     = portOvercurrentSense;

  ppsc_sync u_sync (
    .clk  (clk),
    .rst  (rst),
    .ce   (ce),
    .din  (pinsRaw),
    .dout (pinsS)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  ppsc_state_t state_r;
  ppsc_state_t state_nxt;

  // Sync flops reset low, so HOLD outlasts POR until the pins have filled
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      PPSC_HOLD:  if (pinsS.extRstN) state_nxt = PPSC_LATCH;
      PPSC_LATCH: state_nxt = pinsS.extRstN ? PPSC_RUN : PPSC_HOLD;
      PPSC_RUN:   if (!pinsS.extRstN) state_nxt = PPSC_HOLD;
      default:    state_nxt = PPSC_HOLD;
    endcase
    if (!ce)
      state_nxt = state_r;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_r <= PPSC_HOLD;
    else
      state_r <= state_nxt;
  end

  logic running;
  assign running    = (state_r == PPSC_RUN);
  assign configDone = running;

  // Strap chain frozen in run, so straps count only around reset rise
  logic [1:0] nrStrapS_r;
  logic [1:0] nrStrap1_r;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      nrStrap1_r <= `PPSC_NR_NONE;
      nrStrapS_r <= `PPSC_NR_NONE;
    end
    else if (ce && !running)
    begin
      nrStrap1_r <= fixedDeviceStraps;
      nrStrapS_r <= nrStrap1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] dynReg_r;
  logic [7:0] dynReg_nxt;
  logic [7:0] fixReg_r;
  logic [7:0] fixReg_nxt;
  logic [7:0] rdData_r;
  logic [7:0] rdData_nxt;

  always_comb
  begin
    dynReg_nxt = dynReg_r;
    fixReg_nxt = fixReg_r;
    if (ce && otpLoad)
      dynReg_nxt = otpData;
    if (ce && regWrEn && regAddr == `PPSC_DYNPWR_ADDR)
      dynReg_nxt = regWrData;
    if (ce && regWrEn && regAddr == `PPSC_FIXDEV_ADDR)
      fixReg_nxt = regWrData;
    unique case (regAddr)
      `PPSC_DYNPWR_ADDR: rdData_nxt = dynReg_r;
      `PPSC_FIXDEV_ADDR: rdData_nxt = fixReg_r;
      default:           rdData_nxt = `PPSC_RD_ZERO;
    endcase
    if (!ce)
      rdData_nxt = rdData_r;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dynReg_r <= `PPSC_DYNPWR_RST;
      fixReg_r <= `PPSC_FIXDEV_RST;
      rdData_r <= `PPSC_RD_ZERO;
    end
    else
    begin
      dynReg_r <= dynReg_nxt;
      fixReg_r <= fixReg_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  assign regRdData = rdData_r;

  logic dynamicMode;
  assign dynamicMode = (dynReg_r == `PPSC_DYNPWR_DYN);

  ////////////////////////////////////////////////////////////////////////////
  // Straps, status and power

  ppsc_status_t status_r;
  ppsc_status_t status_nxt;
  ppsc_ports_t  power_r;
  ppsc_ports_t  power_nxt;
  ppsc_ports_t  strapFix;
  ppsc_ports_t  ocNow;
  ppsc_ports_t [1:0] oeDly_r;
  ppsc_ports_t [1:0] oeDly_nxt;

  always_comb
  begin
    unique case (nrStrapS_r)
      `PPSC_NR_NONE: strapFix = `PPSC_FIX_NONE;
      `PPSC_NR_P1:   strapFix = `PPSC_FIX_P1;
      `PPSC_NR_P12:  strapFix = `PPSC_FIX_P12;
      default:       strapFix = `PPSC_FIX_ALL;
    endcase
  end

  // Sense masked by oe delayed like the pin sync, else a false trip at power-on
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_port
      assign ocNow[gi] = combinedCtrlMode
                       ? (!oeDly_r[1][gi] && !pinsS.pinIn[gi])
                       : !pinsS.ocSense[gi];
      assign portPinOut[gi] = combinedCtrlMode ? 1'b0 : power_r[gi];
      assign portPinOe[gi]  = combinedCtrlMode ? (running && !power_r[gi])
                                               : running;
    end
  endgenerate

  always_comb
  begin
    status_nxt = status_r;
    power_nxt  = running ? portPowerReq : `PPSC_PORTS_OFF;
    oeDly_nxt  = {oeDly_r[0], portPinOe};
    if (state_r == PPSC_LATCH)
    begin
      status_nxt.chargeSupport = pinsS.pinIn;
      status_nxt.selfPowered   = pinsS.localSupply;
    end
    else if (running && dynamicMode)
      status_nxt.selfPowered = pinsS.localSupply;
    status_nxt.fixedDevice = localDetectUsed
                           ? fixReg_r[`PPSC_FIXDEV_MSB:`PPSC_FIXDEV_LSB]
                           : strapFix;
    status_nxt.overcurrent = running ? ocNow : `PPSC_PORTS_OFF;
    if (!ce)
    begin
      status_nxt = status_r;
      power_nxt  = power_r;
      oeDly_nxt  = oeDly_r;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      status_r <= '0;
      power_r  <= `PPSC_PORTS_OFF;
      oeDly_r  <= '0;
    end
    else
    begin
      status_r <= status_nxt;
      power_r  <= power_nxt;
      oeDly_r  <= oeDly_nxt;
    end
  end

  // A 1 means local supply present, 0 bus powered
  assign status          = status_r;
  assign portPowerEnable = power_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_power_off_cfg: assert property ((state_r != PPSC_RUN) && $past(state_r) != PPSC_RUN
    |-> portPowerEnable == `PPSC_PORTS_OFF)
    else $error("power on outside run");
  a_power_follow: assert property (ce && running && $past(running) |=>
    portPowerEnable == $past(portPowerReq))
    else $error("power enable not following request");
  a_od_drive_low: assert property (combinedCtrlMode |->
    ((portPinOut & portPinOe) == `PPSC_PORTS_OFF) && ((portPinOe & power_r) == 3'h0))
    else $error("combined pin driven high");
  a_strap_latch: assert property (ce && state_r == PPSC_LATCH |=>
    status.chargeSupport == $past(pinsS.pinIn))
    else $error("charge strap not latched");
  a_local_sample: assert property (ce && state_r == PPSC_LATCH |=>
    status.selfPowered == $past(pinsS.localSupply))
    else $error("local supply not sampled");
  a_local_hold: assert property (running && !dynamicMode && state_nxt == PPSC_RUN |=>
    $stable(status.selfPowered))
    else $error("local supply changed while static");
  a_dyn_reset: assert property ($fell(rst) |-> dynReg_r == `PPSC_DYNPWR_RST)
    else $error("dynamic register reset value wrong");
  a_reg_write: assert property (ce && regWrEn && regAddr == `PPSC_DYNPWR_ADDR |=>
    dynReg_r == $past(regWrData) ##1
    ($past(regAddr) != `PPSC_DYNPWR_ADDR || regRdData == $past(dynReg_r)))
    else $error("dynamic register write lost");
  a_fixed_sel: assert property (ce && localDetectUsed |=>
    status.fixedDevice == $past(fixReg_r[`PPSC_FIXDEV_MSB:`PPSC_FIXDEV_LSB]))
    else $error("fixed device not from register");
  a_reset_latch: assert property ($rose(pinsS.extRstN) && state_r == PPSC_HOLD && ce
    |=> state_r == PPSC_LATCH)
    else $error("strap capture missed on reset rise");
  a_oc_report: assert property (ce && running && !combinedCtrlMode |=>
    status.overcurrent == ~$past(pinsS.ocSense))
    else $error("over-current not reported");

  c_dyn_enable: cover property (regWrEn && regAddr == `PPSC_DYNPWR_ADDR
    && regWrData == `PPSC_DYNPWR_DYN ##1 dynamicMode);
  c_ext_reset: cover property (running ##1 state_r == PPSC_HOLD ##[1:20] running);
  c_oc_combined: cover property (combinedCtrlMode && running && status.overcurrent != 3'h0);

endmodule

`default_nettype wire

// ==== tb/ppsc_port_switch_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module ppsc_port_switch_model
  import ppsc_pkg::*;
(
  // Design side of the shared pins
  input  wire ppsc_ports_t pinOut,
  input  wire ppsc_ports_t pinOe,
  output ppsc_ports_t      pinLevel,
  output ppsc_ports_t      ocSenseN,
  // Bench controls
  input  wire ppsc_ports_t strapLevel,
  input  wire ppsc_ports_t fault
);
  // Released pin: a faulting switch wins over resistor or pull-up
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      pinLevel[i] = pinOe[i] ? pinOut[i] : (fault[i] ? 1'h0 : strapLevel[i]);
    end
  end
  // Detector pulls its flag low on a fault
  assign ocSenseN = ~fault;
endmodule

`default_nettype wire

// ==== tb/ppsc_port_power_strap_control_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ppsc_consts.svh"

module ppsc_port_power_strap_control_test
  import ppsc_pkg::*;
();
  logic         clk, rst, ce, extResetN, localSupply, combMode, localUsed;
  logic         regWrEn, otpLoad, configDone;
  logic [1:0]   fixStraps;
  logic [15:0]  regAddr;
  logic [7:0]   regWrData, regRdData, otpData;
  ppsc_ports_t  ocSenseN, pinIn, pinOut, pinOe, powerReq, powerEn, strapLevel, fault;
  ppsc_status_t status;
  int           mismatches, checks_done;

  ////////////////////////////////////////////////////////////////////
  ppsc_port_power_strap_control dut (.clk(clk), .rst(rst), .ce(ce),
    .extResetN(extResetN), .localSupplyDetect(localSupply),
    .fixedDeviceStraps(fixStraps), .portOvercurrentSense(ocSenseN),
    .portPinIn(pinIn), .portPinOut(pinOut), .portPinOe(pinOe),
    .combinedCtrlMode(combMode), .localDetectUsed(localUsed),
    .portPowerReq(powerReq), .portPowerEnable(powerEn), .status(status),
    .configDone(configDone), .regWrEn(regWrEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .otpLoad(otpLoad), .otpData(otpData));

  ppsc_port_switch_model sw (.pinOut(pinOut), .pinOe(pinOe), .pinLevel(pinIn),
    .ocSenseN(ocSenseN), .strapLevel(strapLevel), .fault(fault));

  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////
  // Inputs move 2 ns after the edge, clear of sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrReg(input logic [15:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'h1;
    cyc(1);
    regWrEn = 1'h0;
  endtask

  // Readback lags the address by one edge
  task automatic rdReg(input logic [15:0] a, input logic [7:0] exp);
    regAddr = a;
    cyc(2);
    chk(regRdData, exp);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Bounded wait for the run state
  task automatic waitRun();
    int k;
    k = 0;
    while (configDone !== 1'h1 && k < 40)
    begin
      cyc(1);
      k++;
    end
    if (configDone === 1'h1)
      cyc(2);
    else
    begin
      mismatches++;
      wrap_up();
    end
  endtask

  ////////////////////////////////////////////////////////////////////
  initial
  begin
    mismatches = 0;
    checks_done = 0;
    rst = 1'h1;
    ce = 1'h1;
    extResetN = 1'h1;
    localSupply = 1'h1;
    fixStraps = 2'h3;
    combMode = 1'h0;
    localUsed = 1'h0;
    regWrEn = 1'h0;
    regAddr = `PPSC_DYNPWR_ADDR;
    regWrData = 8'h00;
    otpLoad = 1'h0;
    otpData = 8'h00;
    powerReq = 3'h0;
    strapLevel = 3'h5;
    fault = 3'h0;
    cyc(12);
    rst = 1'h0;
    waitRun();
    chk(status.chargeSupport, 3'h5);
    chk(status.selfPowered, 1'h1);
    chk(status.fixedDevice, `PPSC_FIX_ALL);
    // Strap moves in run: the latched value must stand
    fixStraps = 2'h1;
    rdReg(`PPSC_DYNPWR_ADDR, 8'hC1);
    rdReg(16'h4136, 8'h00);
    chk(status.fixedDevice, `PPSC_FIX_ALL);
    strapLevel = 3'h7;
    powerReq = 3'h6;
    cyc(2);
    chk(powerEn, 3'h6);
    chk(pinOut, 3'h6);
    // Clock enable low freezes the enables
    ce = 1'h0;
    powerReq = 3'h1;
    cyc(3);
    chk(powerEn, 3'h6);
    ce = 1'h1;
    powerReq = 3'h6;
    localSupply = 1'h0;
    cyc(6);
    chk(status.selfPowered, 1'h1);
    wrReg(`PPSC_DYNPWR_ADDR, 8'h41);
    cyc(6);
    chk(status.selfPowered, 1'h0);
    rdReg(`PPSC_DYNPWR_ADDR, 8'h41);
    // OTP restores static mode
    otpData = 8'hC1;
    otpLoad = 1'h1;
    cyc(1);
    otpLoad = 1'h0;
    rdReg(`PPSC_DYNPWR_ADDR, 8'hC1);
    localSupply = 1'h1;
    cyc(6);
    chk(status.selfPowered, 1'h0);
    fault = 3'h2;
    cyc(5);
    chk(status.overcurrent, 3'h2);
    // Combined pin: only powered ports can sense
    combMode = 1'h1;
    powerReq = 3'h1;
    fault = 3'h0;
    cyc(3);
    chk(pinOe, 3'h6);
    chk(pinOut, 3'h0);
    fault = 3'h3;
    cyc(5);
    chk(status.overcurrent, 3'h1);
    fault = 3'h0;
    combMode = 1'h0;
    localUsed = 1'h1;
    wrReg(`PPSC_FIXDEV_ADDR, 8'h05);
    strapLevel = 3'h2;
    localSupply = 1'h0;
    extResetN = 1'h0;
    cyc(5);
    chk(powerEn, 3'h0);
    chk(pinOe, 3'h0);
    extResetN = 1'h1;
    waitRun();
    chk(status.chargeSupport, 3'h2);
    chk(status.selfPowered, 1'h0);
    chk(status.fixedDevice, 3'h5);
    localUsed = 1'h0;
    cyc(2);
    chk(status.fixedDevice, `PPSC_FIX_P1);
    wrap_up();
  end
endmodule

`default_nettype wire
